// *** include/chan_regs_cfg.svh ***
// Purpose: offsets, field positions, reset values for the channel regs
// Assumes: AXI4-Lite, 32-bit data, byte address = index * 4
// Notes: index = byte address [9:2]
//
// What this block does
// RULE1: green gain index 03h, resets 80h
// RULE2: green offset index 04h, bits 0-6, 40h
// RULE3: blue gain index 05h, resets 80h
// RULE4: blue offset index 06h, bits 0-6, 40h
// RULE5: mono gain index 07h, resets 80h
// RULE6: mono offset index 08h, bits 0-6, 40h
// RULE7: colour select bits 0-1 of 09h, reset 00
// RULE8: 00 rgb, 01 white, 10 mono, 11 rgb
// RULE9: white mode drives normalised r+g+b sum
// RULE10: host uses white mode only when filterless
// RULE11: sequence mode bits 2-4, resets 000
// RULE12: scan direction bit 5, resets 0
// RULE13: direction source bit 6, resets 0
// RULE14: soft reset bit 7, active high, 0
// RULE15: source 1 uses bit, 0 uses pin
// RULE16: soft reset clears registers, powers down
// RULE17: leaving soft reset gives 600-row default
// RULE18: offset bit 7 reads zero, ignores writes
`ifndef CHAN_REGS_CFG_SVH
`define CHAN_REGS_CFG_SVH

`define IDX_GREEN_GAIN 8'h03
`define IDX_GREEN_OFFSET 8'h04
`define IDX_BLUE_GAIN 8'h05
`define IDX_BLUE_OFFSET 8'h06
`define IDX_MONO_GAIN 8'h07
`define IDX_MONO_OFFSET 8'h08
`define IDX_VERTICAL_MODE_CONTROL 8'h09

`define RST_GAIN 8'h80
`define RST_OFFSET 7'h40
`define RST_COLOUR 2'h0
`define RST_VSEQ 3'h0
`define RST_BIT 1'b0

`define OFFSET_MSB 6
`define VM_COLOUR_LSB 0
`define VM_VSEQ_LSB 2
`define VM_DIR_BIT 5
`define VM_SRC_BIT 6
`define VM_SOFT_BIT 7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** include/chan_regs_pkg.sv ***
// Purpose: shared types for the channel gain/offset/mode registers
// Assumes: nothing
// Notes: write handshake states are one-hot
package chan_regs_pkg;

	typedef enum logic [1:0] {
		CM_RGB = 2'h0,
		CM_WHITE = 2'h1,
		CM_MONO = 2'h2,
		CM_RGB_ALT = 2'h3
	} colour_mode_t;

	typedef enum logic [1:0] {
		WS_COLLECT = 2'h1,
		WS_RESP = 2'h2
	} wr_state_t;

	function automatic logic [7:0] word_idx(input logic [31:0] a);
		return a[9:2];
	endfunction

endpackage

// *** hdl/axil_reg_port.sv ***
// Purpose: AXI4-Lite slave front end for a small register bank
// Assumes: bank answers mapping combinationally
// Notes: one write and one read in flight at most
`timescale 1ns/1ps
`default_nettype none
`include "chan_regs_cfg.svh"
module axil_reg_port
	import chan_regs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic wr_en,
	output logic [7:0] wr_idx,
	output logic [7:0] wr_data,
	output logic wr_be0,
	input wire logic wr_ok,
	output logic [7:0] rd_idx,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	wr_state_t state_r;
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wstrb0_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic resp_done;

	// address and data may arrive in either order
	assign awready = (state_r == WS_COLLECT) && !aw_held_r;
	assign wready = (state_r == WS_COLLECT) && !w_held_r;
	assign wr_en = (state_r == WS_COLLECT) && aw_held_r && w_held_r;
	assign wr_idx = word_idx({{(32-ADDR_W){1'b0}}, awaddr_r});
	assign wr_data = wdata_r;
	assign wr_be0 = wstrb0_r;
	assign bvalid = (state_r == WS_RESP);
	assign bresp = bresp_r;
	assign resp_done = (state_r == WS_RESP) && bready;
	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign rd_idx = word_idx({{(32-ADDR_W){1'b0}}, araddr});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= WS_COLLECT;
		end else begin
			case (state_r)
				WS_COLLECT: if (wr_en) state_r <= WS_RESP;
				WS_RESP: if (bready) state_r <= WS_COLLECT;
				default: state_r <= WS_COLLECT;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= awaddr;
		end else if (resp_done) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			wdata_r <= wdata[7:0];
			wstrb0_r <= wstrb[0];
		end else if (resp_done) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp_r <= `RESP_OKAY;
		end else if (wr_en) begin
			bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// unmapped reads answer zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_ok ? rd_data : 32'h0;
			rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** hdl/video_colour_mux.sv ***
// Purpose: picks rgb, white-only or mono samples per colour mode
// Assumes: samples synchronous to aclk
// Notes: one cycle of latency, zero while powered down
`timescale 1ns/1ps
`default_nettype none
module video_colour_mux
	import chan_regs_pkg::*;
#(
	parameter int PIX_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_down,
	input wire colour_mode_t colour_select,
	input wire logic [PIX_W-1:0] red_in,
	input wire logic [PIX_W-1:0] green_in,
	input wire logic [PIX_W-1:0] blue_in,
	input wire logic [PIX_W-1:0] mono_in,
	output logic [PIX_W-1:0] sub_r,
	output logic [PIX_W-1:0] sub_g,
	output logic [PIX_W-1:0] sub_b
);
	logic [PIX_W+1:0] sum;
	logic [PIX_W-1:0] white;

	assign sum = {2'b00, red_in} + {2'b00, green_in} + {2'b00, blue_in};
	// divide by three keeps full white at full scale
	assign white = PIX_W'(sum / (PIX_W+2)'(3));

	always_ff @(posedge aclk) begin
		if (!aresetn || power_down) begin
			sub_r <= '0;
			sub_g <= '0;
			sub_b <= '0;
		end else begin
			case (colour_select)
				// RULE9 all subpixels white
				CM_WHITE: begin
					sub_r <= white;
					sub_g <= white;
					sub_b <= white;
				end
				// RULE8 mono input
				CM_MONO: begin
					sub_r <= mono_in;
					sub_g <= mono_in;
					sub_b <= mono_in;
				end
				default: begin
					sub_r <= red_in;
					sub_g <= green_in;
					sub_b <= blue_in;
				end
			endcase
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_WHITE_SUM: assert property ( // RULE9
		colour_select == CM_WHITE && !power_down |=>
		sub_r == $past(white) && sub_g == sub_r && sub_b == sub_r)
		else $error("white mode output is not the rgb sum");
	AST_MONO_PICK: assert property ( // RULE8
		colour_select == CM_MONO && !power_down |=>
		sub_r == $past(mono_in) && sub_b == $past(mono_in))
		else $error("mono mode output does not follow mono input");
	AST_RGB_ALT: assert property ( // RULE8
		colour_select == CM_RGB_ALT && !power_down |=>
		sub_g == $past(green_in) && sub_b == $past(blue_in))
		else $error("code 11 does not pass rgb");
	COV_WHITE: cover property (colour_select == CM_WHITE && !power_down);
endmodule
`default_nettype wire

// *** hdl/channel_gain_offset_mode_regs.sv ***
// Purpose: green/blue/mono gain and offset, vertical mode register
// Assumes: AXI4-Lite master, ud_pin already synchronous
// Notes: soft reset holds every other field at its reset value
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "chan_regs_cfg.svh"
module channel_gain_offset_mode_regs
	import chan_regs_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int PIX_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic ud_pin,
	input wire logic [PIX_W-1:0] red_in,
	input wire logic [PIX_W-1:0] green_in,
	input wire logic [PIX_W-1:0] blue_in,
	input wire logic [PIX_W-1:0] mono_in,
	output logic [7:0] green_gain,
	output logic [6:0] green_offset,
	output logic [7:0] blue_gain,
	output logic [6:0] blue_offset,
	output logic [7:0] mono_gain,
	output logic [6:0] mono_offset,
	output colour_mode_t colour_select,
	output logic [2:0] vertical_sequence_select,
	output logic scan_up,
	output logic power_down,
	output logic init_default,
	output logic [PIX_W-1:0] sub_r,
	output logic [PIX_W-1:0] sub_g,
	output logic [PIX_W-1:0] sub_b
);
	logic wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_be0;
	logic wr_ok;
	logic [7:0] rd_idx;
	logic [31:0] rd_data;
	logic rd_ok;

	logic [7:0] green_gain_r;
	logic [6:0] green_offset_r;
	logic [7:0] blue_gain_r;
	logic [6:0] blue_offset_r;
	logic [7:0] mono_gain_r;
	logic [6:0] mono_offset_r;
	colour_mode_t colour_r;
	logic [2:0] vseq_r;
	logic vdir_r;
	logic vsrc_r;
	logic soft_r;
	logic scan_up_r;
	logic init_default_r;
	logic hold;

	function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
		return wr_en && wr_be0 && (idx == want);
	endfunction

	function automatic logic mapped(input logic [7:0] idx);
		return (idx >= `IDX_GREEN_GAIN) && (idx <= `IDX_VERTICAL_MODE_CONTROL);
	endfunction

	axil_reg_port #(
		.ADDR_W(ADDR_W)
	) u_port (
		.aclk(aclk),
		.aresetn(aresetn),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_be0(wr_be0),
		.wr_ok(wr_ok),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	assign wr_ok = mapped(wr_idx);
	// RULE16 soft reset holds everything but bit 7
	assign hold = !aresetn || soft_r;

	// RULE1 green gain
	always_ff @(posedge aclk) begin
		if (hold) begin
			green_gain_r <= `RST_GAIN;
		end else if (hit(wr_idx, `IDX_GREEN_GAIN)) begin
			green_gain_r <= wr_data;
		end
	end

	// RULE2 green offset, low seven bits
	always_ff @(posedge aclk) begin
		if (hold) begin
			green_offset_r <= `RST_OFFSET;
		end else if (hit(wr_idx, `IDX_GREEN_OFFSET)) begin
			green_offset_r <= wr_data[`OFFSET_MSB:0];
		end
	end

	// RULE3 blue gain
	always_ff @(posedge aclk) begin
		if (hold) begin
			blue_gain_r <= `RST_GAIN;
		end else if (hit(wr_idx, `IDX_BLUE_GAIN)) begin
			blue_gain_r <= wr_data;
		end
	end

	// RULE4 blue offset
	always_ff @(posedge aclk) begin
		if (hold) begin
			blue_offset_r <= `RST_OFFSET;
		end else if (hit(wr_idx, `IDX_BLUE_OFFSET)) begin
			blue_offset_r <= wr_data[`OFFSET_MSB:0];
		end
	end

	// RULE5 mono gain
	always_ff @(posedge aclk) begin
		if (hold) begin
			mono_gain_r <= `RST_GAIN;
		end else if (hit(wr_idx, `IDX_MONO_GAIN)) begin
			mono_gain_r <= wr_data;
		end
	end

	// RULE6 mono offset
	always_ff @(posedge aclk) begin
		if (hold) begin
			mono_offset_r <= `RST_OFFSET;
		end else if (hit(wr_idx, `IDX_MONO_OFFSET)) begin
			mono_offset_r <= wr_data[`OFFSET_MSB:0];
		end
	end

	// RULE14 soft reset bit, writable even while set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_r <= `RST_BIT;
		end else if (hit(wr_idx, `IDX_VERTICAL_MODE_CONTROL)) begin
			soft_r <= wr_data[`VM_SOFT_BIT];
		end
	end

	// RULE7 RULE11 RULE12 RULE13 mode fields reset to zero
	// a write that also sets bit 7 loads nothing, fields are default one cycle after bit 7 sets
	always_ff @(posedge aclk) begin
		if (hold) begin
			colour_r <= colour_mode_t'(`RST_COLOUR);
			vseq_r <= `RST_VSEQ;
			vdir_r <= `RST_BIT;
			vsrc_r <= `RST_BIT;
		end else if (hit(wr_idx, `IDX_VERTICAL_MODE_CONTROL) && !wr_data[`VM_SOFT_BIT]) begin
			colour_r <= colour_mode_t'(wr_data[`VM_COLOUR_LSB +: 2]);
			vseq_r <= wr_data[`VM_VSEQ_LSB +: 3];
			vdir_r <= wr_data[`VM_DIR_BIT];
			vsrc_r <= wr_data[`VM_SRC_BIT];
		end
	end

	// RULE17 one pulse as soft reset clears, fields already default
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_default_r <= 1'b0;
		end else begin
			init_default_r <= soft_r && hit(wr_idx, `IDX_VERTICAL_MODE_CONTROL) &&
				!wr_data[`VM_SOFT_BIT];
		end
	end

	// RULE15 direction from bit 5 or from the pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_up_r <= 1'b0;
		end else begin
			scan_up_r <= vsrc_r ? vdir_r : ud_pin;
		end
	end

	// RULE18 offset bit 7 reads zero
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0;
		if (rd_idx == `IDX_GREEN_GAIN) begin
			rd_data[7:0] = green_gain_r;
		end else if (rd_idx == `IDX_GREEN_OFFSET) begin
			rd_data[`OFFSET_MSB:0] = green_offset_r;
		end else if (rd_idx == `IDX_BLUE_GAIN) begin
			rd_data[7:0] = blue_gain_r;
		end else if (rd_idx == `IDX_BLUE_OFFSET) begin
			rd_data[`OFFSET_MSB:0] = blue_offset_r;
		end else if (rd_idx == `IDX_MONO_GAIN) begin
			rd_data[7:0] = mono_gain_r;
		end else if (rd_idx == `IDX_MONO_OFFSET) begin
			rd_data[`OFFSET_MSB:0] = mono_offset_r;
		end else if (rd_idx == `IDX_VERTICAL_MODE_CONTROL) begin
			rd_data[7:0] = {soft_r, vsrc_r, vdir_r, vseq_r, colour_r};
		end else begin
			rd_ok = 1'b0;
		end
	end

	assign green_gain = green_gain_r;
	assign green_offset = green_offset_r;
	assign blue_gain = blue_gain_r;
	assign blue_offset = blue_offset_r;
	assign mono_gain = mono_gain_r;
	assign mono_offset = mono_offset_r;
	assign colour_select = colour_r;
	assign vertical_sequence_select = vseq_r;
	assign scan_up = scan_up_r;
	assign power_down = soft_r;
	assign init_default = init_default_r;

	// video path shares the power-down of the sequencers
	video_colour_mux #(
		.PIX_W(PIX_W)
	) u_mux (
		.aclk(aclk),
		.aresetn(aresetn),
		.power_down(soft_r),
		.colour_select(colour_r),
		.red_in(red_in),
		.green_in(green_in),
		.blue_in(blue_in),
		.mono_in(mono_in),
		.sub_r(sub_r),
		.sub_g(sub_g),
		.sub_b(sub_b)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_GG_SOFT: assert property ( // RULE1
		soft_r |=> green_gain == 8'h80)
		else $error("green gain not 80h under soft reset");
	AST_GG_WRITE: assert property ( // RULE1
		!soft_r && wr_en && wr_be0 && wr_idx == `IDX_GREEN_GAIN |=>
		green_gain == $past(wr_data))
		else $error("green gain write lost");
	AST_GO_SOFT: assert property ( // RULE2
		soft_r |=> green_offset == 7'h40)
		else $error("green offset not 40h under soft reset");
	AST_BG_WRITE: assert property ( // RULE3
		!soft_r && wr_en && wr_be0 && wr_idx == `IDX_BLUE_GAIN |=>
		blue_gain == $past(wr_data) ##1 $stable(blue_gain) || soft_r)
		else $error("blue gain write lost");
	AST_BO_SOFT: assert property ( // RULE4
		soft_r |=> blue_offset == 7'h40)
		else $error("blue offset not 40h under soft reset");
	AST_MG_WRITE: assert property ( // RULE5
		!soft_r && wr_en && wr_be0 && wr_idx == `IDX_MONO_GAIN |=>
		mono_gain == $past(wr_data))
		else $error("mono gain write lost");
	AST_MO_WRITE: assert property ( // RULE6
		!soft_r && wr_en && wr_be0 && wr_idx == `IDX_MONO_OFFSET |=>
		mono_offset == $past(wr_data[6:0]))
		else $error("mono offset write lost");
	AST_OFF_RSV: assert property ( // RULE18
		rd_idx == `IDX_BLUE_OFFSET |-> rd_data[31:7] == 25'h0)
		else $error("offset reserved bit reads nonzero");
	AST_VSEQ_WRITE: assert property ( // RULE11
		!soft_r && wr_en && wr_be0 && wr_idx == `IDX_VERTICAL_MODE_CONTROL &&
		!wr_data[7] |=>
		vertical_sequence_select == $past(wr_data[4:2]) &&
		colour_select == $past(wr_data[1:0]))
		else $error("vertical mode fields not loaded");
	AST_SOFT_HOLD: assert property ( // RULE16
		soft_r |=> (power_down || init_default) && sub_r == '0 &&
		vertical_sequence_select == 3'h0 && colour_select == CM_RGB)
		else $error("soft reset did not hold defaults");
	AST_DIR: assert property ( // RULE15
		1'b1 |=> scan_up == ($past(vsrc_r) ? $past(vdir_r) : $past(ud_pin)))
		else $error("scan direction from wrong source");
	AST_INIT: assert property ( // RULE17
		$fell(soft_r) |-> init_default && vertical_sequence_select == 3'h0
		##1 !init_default)
		else $error("no single init pulse on soft reset exit");
	AST_INIT_ONLY: assert property ( // RULE17
		init_default |-> $fell(soft_r))
		else $error("init pulse without soft reset exit");

	COV_SOFT_EXIT: cover property ($fell(soft_r));
	// direct terms: a function body here would see post-edge values
	COV_GAIN_WR: cover property (wr_en && wr_be0 &&
		wr_idx == `IDX_GREEN_GAIN && !soft_r);
	COV_PIN_DIR: cover property (!vsrc_r && ud_pin ##1 scan_up);
endmodule
`default_nettype wire

// *** tb/axil_host.sv ***
// Purpose: AXI4-Lite host model for the channel register bank
// Assumes: slave answers in its own time; bench timeout cuts hangs
// Notes: lag holds back bready/rready to act as a slow host
`timescale 1ns/1ps
`default_nettype none
module axil_host (
	input wire logic aclk,
	output logic awvalid,
	input wire logic awready,
	output logic [11:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [11:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	int lag = 0;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr} = 24'h000000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
	end
	// released lines flip so a stale value never looks valid
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		repeat (lag) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		repeat (lag) @(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the channel gain/offset/mode regs
// Assumes: axil_host drives the register bus
// Notes: lfsr stimulus from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ud_pin = 1'b0;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, s;
	logic [1:0] bresp, rresp, cs, resp;
	logic [7:0] r_in = 8'h00, g_in = 8'h00, b_in = 8'h00, m_in = 8'h00;
	logic [7:0] gg, bg, mg, sr, sg, sb, v;
	logic [6:0] go, bo, mo;
	logic [2:0] vss;
	logic scan_up, power_down, init_default;
	logic [15:0] seed = 16'hd472;
	logic [7:0] m [3:9];
	logic [11:0] bad_a [4] = '{12'h000, 12'h008, 12'h028, 12'h3fc};
	int bad_count = 0, num_checks = 0, cycles = 0, pulses = 0, i;

	channel_gain_offset_mode_regs channel_gain_offset_mode_regs_i (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .ud_pin(ud_pin),
		.red_in(r_in), .green_in(g_in), .blue_in(b_in), .mono_in(m_in),
		.green_gain(gg), .green_offset(go), .blue_gain(bg),
		.blue_offset(bo), .mono_gain(mg), .mono_offset(mo),
		.colour_select(cs), .vertical_sequence_select(vss),
		.scan_up(scan_up), .power_down(power_down),
		.init_default(init_default), .sub_r(sr), .sub_g(sg), .sub_b(sb));
	axil_host axil_host_i (
		.aclk(aclk), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	initial forever #12.5 aclk = ~aclk;
	// a whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (init_default) pulses <= pulses + 1;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction
	function automatic logic [7:0] reg_mask(input int k, input logic [7:0] x);
		return (k == 4 || k == 6 || k == 8) ? {1'b0, x[6:0]} : x;
	endfunction
	function automatic logic [23:0] sub_exp(input logic [1:0] c,
		input logic [7:0] r, g, b, mono);
		logic [9:0] sum;
		sum = r + g + b;
		case (c)
			2'h1: return {3{8'(sum / 3)}};
			2'h2: return {3{mono}};
			default: return {r, g, b};
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic set_defaults();
		for (int k = 3; k <= 8; k++) m[k] = k[0] ? 8'h80 : 8'h40;
		m[9] = 8'h00;
	endtask
	task automatic rd_chk(input int k);
		logic [31:0] rd_d;
		logic [1:0] rd_r;
		axil_host_i.rd(12'(k * 4), rd_d, rd_r);
		chk(rd_d, {24'h0, m[k]});
		chk(rd_r, 2'h0);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		set_defaults();
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 3; k <= 9; k++) rd_chk(k);
		for (int n = 0; n < 40; n++) begin
			axil_host_i.lag = n % 3;
			i = 3 + int'(rnd() % 16'd7);
			v = 8'(rnd());
			s = 4'(rnd());
			v[7] = (i == 9) ? 1'b0 : v[7];
			axil_host_i.wr(12'(i * 4), {rnd(), 8'hc3, v}, s, resp);
			chk(resp, 2'h0);
			if (s[0]) m[i] = reg_mask(i, v);
			rd_chk(i);
		end
		chk({gg, 1'b0, go, bg, 1'b0, bo}, {m[3], m[4], m[5], m[6]});
		chk({mg, 1'b0, mo, vss, cs}, {m[7], m[8], m[9][4:0]});
		// unmapped places answer with an error and change nothing
		foreach (bad_a[k]) begin
			axil_host_i.wr(bad_a[k], 32'hffffffff, 4'hf, resp);
			chk(resp, 2'h2);
			axil_host_i.rd(bad_a[k], d, resp);
			chk({d[29:0], resp}, 32'h2);
		end
		axil_host_i.wr(12'h40c, 32'h5a, 4'h1, resp);
		m[3] = 8'h5a;
		for (int k = 3; k <= 9; k++) rd_chk(k);
		for (int c = 0; c < 16; c++) begin
			{r_in, g_in} <= rnd();
			{b_in, m_in} <= rnd();
			ud_pin <= seed[3];
			v = {1'b0, c[2], c[3], 3'(rnd()), 2'(c)};
			// bench panel taken as filterless for white mode
			axil_host_i.wr(12'h024, {24'h0, v}, 4'h1, resp);
			m[9] = v;
			repeat (2) @(posedge aclk);
			#1;
			chk({scan_up, sr, sg, sb}, {c[2] ? c[3] : ud_pin, sub_exp(2'(c), r_in, g_in, b_in, m_in)});
			rd_chk(9);
		end
		axil_host_i.wr(12'h00c, 32'h11, 4'h1, resp);
		axil_host_i.wr(12'h024, 32'he5, 4'h1, resp);
		i = pulses;
		repeat (2) @(posedge aclk);
		#1;
		chk({power_down, sr, sg, sb}, 32'h1000000);
		axil_host_i.wr(12'h00c, 32'h22, 4'h1, resp);
		chk(resp, 2'h0);
		set_defaults();
		m[9] = 8'h80;
		rd_chk(3);
		rd_chk(9);
		axil_host_i.wr(12'h024, 32'h2d, 4'h1, resp);
		repeat (3) @(posedge aclk);
		#1;
		chk({power_down, 8'(pulses - i)}, 32'h001);
		m[9] = 8'h00;
		for (int k = 3; k <= 9; k++) rd_chk(k);
		finish_test();
	end
endmodule
`default_nettype wire
